//--- shared/dac_bus_pkg.sv
// Purpose: constants shared by the cable-bus host end and the eight-channel converter board end
// Assumes: byte-wide cable bus with 64 locations, one system clock
// Notes:   host window offsets and board function offsets are byte locations
package dac_bus_pkg;
  // cable bus geometry
  localparam int unsigned LOC_W        = 6;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned CODE_W       = 12;
  localparam int unsigned CHAN_N       = 8;
  localparam int unsigned CHSEL_W      = 3;
  // board function offsets from the board location
  localparam logic [2:0] OFS_DATA_HIGH  = 3'h0;
  localparam logic [2:0] OFS_DATA_LOW   = 3'h1;
  localparam logic [2:0] OFS_CHAN_SEL   = 3'h2;
  localparam logic [2:0] OFS_JOINT_MASK = 3'h3;
  localparam logic [2:0] OFS_TRIG_A     = 3'h4;
  localparam logic [2:0] OFS_TRIG_D     = 3'h7;
  // host driver window, relative to its base
  localparam logic [1:0] HOST_DATA_PATH   = 2'h0;
  localparam logic [1:0] HOST_LOC_POINTER = 2'h1;
  localparam logic [1:0] HOST_SOFT_RESET  = 2'h2;
  localparam logic [1:0] HOST_RESERVED    = 2'h3;
  // host status register bit positions (read at the reserved slot)
  localparam int unsigned STAT_RDVALID_BIT = 0;
  // reset values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [11:0] RST_CODE  = 12'h000;
  localparam logic [5:0]  RST_LOC   = 6'h00;
  // code landmarks, both codings
  localparam logic [11:0] CODE_MID  = 12'h800;
  localparam logic [11:0] CODE_TOP  = 12'hFFF;
endpackage

//--- shared/dac_bus_if.sv
// Purpose: byte-wide cable bus between host driver and converter board
// Assumes: both ends on i_clk_sys; host drives every strobe
// Notes:   rd_data is answered by the board one cycle after rd_stb
interface dac_bus_if;
  logic [5:0] loc;        // pointed bus location
  logic [7:0] wr_data;    // byte toward the board
  logic       wr_stb;     // one-cycle write strobe
  logic       rd_stb;     // one-cycle read strobe
  logic       soft_rst;   // one-cycle software reset pulse
  logic [7:0] rd_data;    // readback byte from the board
  logic       rd_valid;   // board answered the read
  modport host (output loc, output wr_data, output wr_stb, output rd_stb, output soft_rst,
                input rd_data, input rd_valid);
  modport board (input loc, input wr_data, input wr_stb, input rd_stb, input soft_rst,
                 output rd_data, output rd_valid);
endinterface

//--- core/dac_bus_host.sv
// Purpose: host driver end: software window of pointer, data path, soft reset
// Assumes: software port with one-cycle strobes, read data one cycle later
// Notes:   every byte goes to the location currently held in the pointer
module dac_bus_host (
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  dac_bus_if.host         bus
);
  logic [5:0] ptr_q;       // bus location pointer
  logic [7:0] last_rd_q;   // last byte read back from the bus
  logic       rd_seen_q;   // a bus read has completed since reset

  // (R03) window decode
  // (R02) pointer loads
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      ptr_q <= dac_bus_pkg::RST_LOC;
    end else if (i_wr && i_addr == dac_bus_pkg::HOST_LOC_POINTER) begin
      ptr_q <= i_wdata[5:0];
    end
  end

  // (R04) byte goes to pointed location
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      bus.loc      <= dac_bus_pkg::RST_LOC;
      bus.wr_data  <= dac_bus_pkg::RST_BYTE;
      bus.wr_stb   <= 1'b0;
      bus.rd_stb   <= 1'b0;
      bus.soft_rst <= 1'b0;
    end else begin
      bus.loc      <= (i_wr && i_addr == dac_bus_pkg::HOST_LOC_POINTER) ? i_wdata[5:0] : ptr_q;
      bus.wr_data  <= i_wdata;
      bus.wr_stb   <= i_wr && i_addr == dac_bus_pkg::HOST_DATA_PATH;
      bus.rd_stb   <= i_rd && i_addr == dac_bus_pkg::HOST_DATA_PATH;
      bus.soft_rst <= i_wr && i_addr == dac_bus_pkg::HOST_SOFT_RESET;
    end
  end

  // capture board answer, three cycles after the software read
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      last_rd_q <= dac_bus_pkg::RST_BYTE;
      rd_seen_q <= 1'b0;
    end else begin
      if (bus.rd_valid) begin
        last_rd_q <= bus.rd_data;
        rd_seen_q <= 1'b1;
      end
    end
  end

  // software read data, one cycle after the strobe
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= dac_bus_pkg::RST_BYTE;
    end else if (i_rd) begin
      unique case (i_addr)
        dac_bus_pkg::HOST_DATA_PATH:   o_rdata <= last_rd_q;
        dac_bus_pkg::HOST_LOC_POINTER: o_rdata <= {2'b00, ptr_q};
        dac_bus_pkg::HOST_SOFT_RESET:  o_rdata <= dac_bus_pkg::RST_BYTE;
        dac_bus_pkg::HOST_RESERVED:    o_rdata <= {7'h00, rd_seen_q};
      endcase
    end else begin
      o_rdata <= dac_bus_pkg::RST_BYTE;
    end
  end
endmodule

//--- core/dac_bus_board.sv
// Purpose: eight-channel 12-bit double-buffered converter board register end
// Assumes: host end drives one-cycle strobes on i_clk_sys
// Notes:   converter codes are raw; coding chosen per channel by i_bipolar
// Overview of operation
// (R01) decode eight locations from board location
// (R02) host pointer selects any of 64
// (R03) host window: data, pointer, reset, reserved
// (R04) host points before each byte
// (R05) soft reset clears outputs, channel, mask
// (R06) jumper chooses clear or hold
// (R07) data latched, converters load on update
// (R08) offset zero high, one low latch
// (R09) offset two selects, reads channel
// (R10) high byte write updates selected channel
// (R11) offset three write-only joint mask
// (R12) offsets four-seven update masked channels
// (R13) unipolar code straight binary
// (R14) bipolar code complementary offset binary
// (R15) high byte MSBs, low D7-D4
// (R16) unwritten low byte reads zeros
// (R17) host selects channel, then writes data
// (R18) low byte before high byte
//
// Design decision made here: the strobed register port.
module dac_bus_board #(
  parameter logic [5:0] BOARD_LOC = 6'h10   // switch-set board location
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_nrst,
  input  wire logic         i_reset_response_jumper, // high: clear on reset
  input  wire logic [7:0]   i_bipolar,               // per-channel coding
  output logic      [95:0]  o_dac_code,              // eight 12-bit codes
  output logic      [7:0]   o_joint_update_sel,
  output logic      [2:0]   o_chan_sel,
  output logic      [95:0]  o_out_level,             // level: unipolar unsigned, bipolar signed
  dac_bus_if.board          bus
);
  // latches and decode for the eight locations; converters are modelled as
  // registered codes, with a level beside each that follows the channel's coding
  logic       jmp_meta_q;   // jumper synchroniser stage one
  logic       jmp_q;        // jumper, synchronised
  logic [7:0] bip_meta_q;   // coding strap synchroniser stage one
  logic [7:0] bip_q;        // coding strap, synchronised
  logic [1:0] init_q;       // cycles since reset release, saturating
  logic       init_clr;     // one-cycle power-up clear
  logic [7:0] hi_q;         // high data byte latch
  logic [3:0] lo_q;         // low nibble latch
  logic       hit;          // access falls in our eight locations
  logic [2:0] ofs;          // function offset
  logic       wr_hit;       // write strobe aimed at our locations
  logic       trig;         // write to one of the update triggers
  logic       load_hi;      // write to the high data byte
  logic       clr;          // clearing action: power-up, or soft reset with jumper set

  // output level per coding: unipolar is the code itself, unsigned;
  // bipolar is two's complement, positive for codes below mid-scale
  function automatic logic [11:0] level(input logic [11:0] code, input logic bip);
    if (!bip) begin
      // (R13) straight binary
      level = code;
    end else if (code == dac_bus_pkg::RST_CODE) begin
      // (R14) code zero is positive full scale, one step short of 2048 to fit
      level = dac_bus_pkg::CODE_MID - 12'h001;
    end else begin
      // (R14) complementary offset binary, mid-scale is zero
      level = dac_bus_pkg::CODE_MID - code;
    end
  endfunction

  // zero-volt code: mid-scale for a bipolar channel, zero for a unipolar one
  function automatic logic [11:0] zero_code(input logic bip);
    zero_code = bip ? dac_bus_pkg::CODE_MID : dac_bus_pkg::RST_CODE;
  endfunction

  // jumper is a pin: two flops first
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      jmp_meta_q <= 1'b0;
      jmp_q      <= 1'b0;
    end else begin
      jmp_meta_q <= i_reset_response_jumper;
      jmp_q      <= jmp_meta_q;
    end
  end

  // coding strap is a pin too: two flops before level and clear logic read it
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      bip_meta_q <= dac_bus_pkg::RST_BYTE;
      bip_q      <= dac_bus_pkg::RST_BYTE;
    end else begin
      bip_meta_q <= i_bipolar;
      bip_q      <= bip_meta_q;
    end
  end

  // power-up clear waits for a settled strap, so bipolar channels get mid-scale;
  // the async reset branch can only load constants
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      init_q <= 2'h0;
    end else if (init_q != 2'h3) begin
      // count up, then stop
      init_q <= init_q + 2'h1;
    end
  end

  // (R01) location decode
  always_comb begin
    // offset within our window; wraps harmlessly when out of range
    ofs      = 3'(bus.loc - BOARD_LOC);
    // distance from the board location, modulo the 64-location bus
    hit      = 6'(bus.loc - BOARD_LOC) < 6'h08;
    wr_hit   = bus.wr_stb && hit;
    trig     = wr_hit && ofs >= dac_bus_pkg::OFS_TRIG_A;
    load_hi  = wr_hit && ofs == dac_bus_pkg::OFS_DATA_HIGH;
    // power-up clear fires once, two cycles after release
    init_clr = init_q == 2'h2;
    // (R06) soft reset clears only when jumper set
    clr      = (bus.soft_rst && jmp_q) || init_clr;
  end

  // (R08) data latches
  // (R15) byte placement: full high byte, top nibble of low byte
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      hi_q <= dac_bus_pkg::RST_BYTE;
      lo_q <= 4'h0;
    end else if (load_hi) begin
      // eight most significant code bits
      hi_q <= bus.wr_data;
    end else if (wr_hit && ofs == dac_bus_pkg::OFS_DATA_LOW) begin
      // four least significant code bits; D3..D0 dropped
      lo_q <= bus.wr_data[7:4];
    end
  end

  // (R09) channel select
  // (R05) reset to channel zero
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_chan_sel <= 3'h0;
    end else if (clr) begin
      // clearing action selects the first output channel
      o_chan_sel <= 3'h0;
    end else if (wr_hit && ofs == dac_bus_pkg::OFS_CHAN_SEL) begin
      // three-bit binary channel number
      o_chan_sel <= bus.wr_data[2:0];
    end
  end

  // (R11) joint update mask
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_joint_update_sel <= dac_bus_pkg::RST_BYTE;
    end else if (clr) begin
      // clearing action drops every channel from joint update
      o_joint_update_sel <= dac_bus_pkg::RST_BYTE;
    end else if (wr_hit && ofs == dac_bus_pkg::OFS_JOINT_MASK) begin
      // bit n includes channel n
      o_joint_update_sel <= bus.wr_data;
    end
  end

  // converter loads; only updates move data (double buffering)
  // (R07) load on update only
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_dac_code  <= '0;
      o_out_level <= '0;
    end else begin
      for (int c = 0; c < 8; c++) begin
        if (clr) begin
          // (R05) zero volts per coding
          o_dac_code[c*12 +: 12]  <= zero_code(bip_q[c]);
          o_out_level[c*12 +: 12] <= dac_bus_pkg::RST_CODE;
        end else if (trig && (o_joint_update_sel[c] || o_chan_sel == 3'(c))) begin
          // (R12) masked and individually selected channels update
          o_dac_code[c*12 +: 12]  <= {hi_q, lo_q};
          o_out_level[c*12 +: 12] <= level({hi_q, lo_q}, bip_q[c]);
        end else if (load_hi && o_chan_sel == 3'(c)) begin
          // (R10) direct update of selected channel
          // (R16) low nibble is zero unless written
          o_dac_code[c*12 +: 12]  <= {bus.wr_data, lo_q};
          o_out_level[c*12 +: 12] <= level({bus.wr_data, lo_q}, bip_q[c]);
        end
      end
    end
  end

  // readback: channel at offset two, zero elsewhere, answered one cycle on
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      bus.rd_data  <= dac_bus_pkg::RST_BYTE;
      bus.rd_valid <= 1'b0;
    end else begin
      // answer only reads aimed at our eight locations
      bus.rd_valid <= bus.rd_stb && hit;
      // (R09) channel readback; write-only places read as zero
      bus.rd_data  <= (bus.rd_stb && hit && ofs == dac_bus_pkg::OFS_CHAN_SEL) ? {5'h00, o_chan_sel}
                                                                            : dac_bus_pkg::RST_BYTE;
    end
  end
endmodule

//--- tb/dac_bus_chk.sv
// Purpose: cable-bus checks between the host end and the board end
// Assumes: one clock, async active-low reset
// Notes:   channel copy is distrusted after a soft reset until rewritten
module dac_bus_chk #(
  parameter logic [5:0] BOARD_LOC = 6'h10
) (
  input wire logic       i_clk_sys,
  input wire logic       i_nrst,
  input wire logic [5:0] loc,
  input wire logic [7:0] wr_data,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic       soft_rst,
  input wire logic [7:0] rd_data,
  input wire logic       rd_valid
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  logic       hit;     // location is one of the board's eight
  logic [2:0] ofs;     // function offset from the board location
  logic [2:0] chan_q;  // last channel written on the bus
  logic       known_q; // channel copy can be trusted
  assign hit = 6'(loc - BOARD_LOC) < 6'h08;
  assign ofs = 3'(loc - BOARD_LOC);
  // shadow of the channel select, lost on soft reset (jumper unseen here)
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      chan_q  <= 3'h0;
      known_q <= 1'b1;
    end else if (wr_stb && hit && ofs == 3'h2) begin
      chan_q  <= wr_data[2:0];
      known_q <= 1'b1;
    end else if (soft_rst) begin
      known_q <= 1'b0;
    end
  end
  a_read_answered: assert property (rd_stb && hit |=> rd_valid) else $error("read unanswered");
  a_far_read_quiet: assert property (rd_stb && !hit |=> !rd_valid) else $error("foreign read answered");
  a_no_stray_answer: assert property (rd_valid |-> $past(rd_stb) && $past(hit)) else $error("stray answer");
  a_chan_readback: assert property (rd_stb && hit && ofs == 3'h2 && known_q |=> rd_data == {5'h00, chan_q})
    else $error("channel readback wrong");
  a_wo_reads_zero: assert property (rd_stb && hit && ofs != 3'h2 |=> rd_data == 8'h00)
    else $error("write-only place read nonzero");
  a_loc_steady: assert property (wr_stb |-> $stable(loc)) else $error("pointer moved under write");
  a_one_strobe: assert property (!(wr_stb && rd_stb)) else $error("two strobes at once");
  a_reset_alone: assert property (soft_rst |-> !wr_stb && !rd_stb) else $error("reset beside transfer");
endmodule

//--- tb/tb_octal_dac_bus_register_interface.sv
// Purpose: bench joining host end and board end over the cable bus
// Assumes: 100 MHz clock, board at location 0x20, channels 4-7 bipolar
// Notes:   expected codes are built from the byte layout only
module tb_octal_dac_bus_register_interface;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] LOC = 6'h20;  // board location under test
  localparam logic [7:0] BIP = 8'hF0;  // per-channel coding strap
  logic        i_clk_sys = 1'b0;
  logic        i_nrst    = 1'b0;
  logic [1:0]  i_addr    = 2'h0;
  logic [7:0]  i_wdata   = 8'h00;
  logic        i_wr      = 1'b0;
  logic        i_rd      = 1'b0;
  logic        jmp       = 1'b0;       // clear-on-reset jumper
  logic [7:0]  rdata, mask, got, h;
  logic [95:0] code, level;
  logic [2:0]  chan;
  logic [11:0] e;
  int          c, k;
  int          bad_count = 0;
  int          total_checks = 0;
  // rows of {channel, high byte, low byte}
  logic [18:0] rows [6] = '{19'h0_FFFF, 19'h1_800F, 19'h3_0000, 19'h4_0000, 19'h5_8000, 19'h7_FFF0};
  dac_bus_if dac_bus_if_inst ();
  dac_bus_host dac_bus_host_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .bus(dac_bus_if_inst.host));
  dac_bus_board #(.BOARD_LOC(LOC)) dac_bus_board_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_reset_response_jumper(jmp), .i_bipolar(BIP), .o_dac_code(code), .o_joint_update_sel(mask),
    .o_chan_sel(chan), .o_out_level(level), .bus(dac_bus_if_inst.board));
  dac_bus_chk #(.BOARD_LOC(LOC)) dac_bus_chk_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .loc(dac_bus_if_inst.loc), .wr_data(dac_bus_if_inst.wr_data), .wr_stb(dac_bus_if_inst.wr_stb),
    .rd_stb(dac_bus_if_inst.rd_stb), .soft_rst(dac_bus_if_inst.soft_rst), .rd_data(dac_bus_if_inst.rd_data),
    .rd_valid(dac_bus_if_inst.rd_valid));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // cleared state: mask and channel zero, every output at zero volts
  task automatic cleared();
    chk({4'h0, mask}, 12'h000);
    chk({9'h000, chan}, 12'h000);
    for (int n = 0; n < 8; n++) begin
      chk(code[12*n +: 12], BIP[n] ? 12'h800 : 12'h000);
      chk(level[12*n +: 12], 12'h000);
    end
  endtask
  // one software cycle; read data is taken in the cycle after the strobe
  task automatic sw(input logic rd, input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr    <= !rd;
    i_rd    <= rd;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr    <= 1'b0;
    i_rd    <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic bwr(input logic [5:0] l, input logic [7:0] d);
    sw(1'b0, dac_bus_pkg::HOST_LOC_POINTER, {2'h0, l});
    sw(1'b0, dac_bus_pkg::HOST_DATA_PATH, d);
    @(posedge i_clk_sys);
    #1;
  endtask
  // data path read is two-step: first launches, second returns
  task automatic brd(input logic [2:0] off);
    sw(1'b0, dac_bus_pkg::HOST_LOC_POINTER, {2'h0, LOC + {3'h0, off}});
    sw(1'b1, dac_bus_pkg::HOST_DATA_PATH, 8'h00);
    repeat (3) @(posedge i_clk_sys);
    sw(1'b1, dac_bus_pkg::HOST_DATA_PATH, 8'h00);
  endtask
  initial forever #5 i_clk_sys = ~i_clk_sys;
  // watchdog cuts a hang short
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    bad_count++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    // power-up clear lands once the coding strap has settled
    repeat (4) @(posedge i_clk_sys);
    #1 cleared();
    sw(1'b1, dac_bus_pkg::HOST_RESERVED, 8'h00);
    chk({4'h0, got}, 12'h000);
    bwr(LOC, 8'hC3);
    chk(code[11:0], 12'hC30);
    // low byte, channel, then high byte
    foreach (rows[i]) begin
      c = int'(rows[i][18:16]);
      e = {rows[i][15:8], rows[i][7:4]};
      bwr(LOC + 6'h1, rows[i][7:0]);
      bwr(LOC + 6'h2, {5'h00, rows[i][18:16]});
      bwr(LOC, rows[i][15:8]);
      chk(code[12*c +: 12], e);
      chk(level[12*c +: 12], !BIP[c] ? e : (e == 12'h000) ? 12'h7FF : 12'h800 - e);
      brd(dac_bus_pkg::OFS_CHAN_SEL);
      chk({4'h0, got}, 12'(c));
    end
    sw(1'b1, dac_bus_pkg::HOST_RESERVED, 8'h00);
    chk({4'h0, got}, 12'h001);
    bwr(LOC + 6'h3, 8'h06);
    chk({4'h0, mask}, 12'h006);
    brd(dac_bus_pkg::OFS_JOINT_MASK);
    chk({4'h0, got}, 12'h000);
    bwr(LOC + 6'h2, 8'h00);
    e = 12'h800;
    for (k = 4; k < 8; k++) begin
      h = 8'h40 + 8'(k);
      bwr(LOC, h);
      chk(code[23:12], e);
      bwr(LOC + 6'(k), 8'hA5);
      e = {h, 4'hF};
      chk(code[23:12], e);
      chk(code[35:24], e);
      chk(code[47:36], 12'h000);
    end
    // a trigger also loads the individually selected channel
    bwr(LOC + 6'h2, 8'h03);
    bwr(LOC + 6'h4, 8'h00);
    chk(code[47:36], e);
    bwr(LOC + 6'h8, 8'h11);
    bwr(LOC - 6'h1, 8'h00);
    chk(code[11:0], e);
    chk(code[23:12], e);
    sw(1'b0, dac_bus_pkg::HOST_LOC_POINTER, 8'h3F);
    sw(1'b1, dac_bus_pkg::HOST_LOC_POINTER, 8'h00);
    chk({4'h0, got}, 12'h03F);
    sw(1'b0, dac_bus_pkg::HOST_SOFT_RESET, 8'h00);
    repeat (2) @(posedge i_clk_sys);
    #1 chk({4'h0, mask}, 12'h006);
    chk(code[23:12], e);
    @(posedge i_clk_sys);
    jmp <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    sw(1'b0, dac_bus_pkg::HOST_SOFT_RESET, 8'h00);
    repeat (2) @(posedge i_clk_sys);
    #1 cleared();
    brd(dac_bus_pkg::OFS_CHAN_SEL);
    chk({4'h0, got}, 12'h000);
    // second reset in mid-run, with a mask loaded beforehand
    bwr(LOC + 6'h3, 8'hFF);
    @(posedge i_clk_sys);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    #1 cleared();
    end_sim();
  end
endmodule
